// ### src/tmo_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

// Level tracker giving rise and fall of a synchronous input
module tmo_edge_det (
   input wire logic clk,
   input wire logic reset,
   input wire logic level_in,
   output logic rise,
   output logic fall
);

   logic prev_r;
   logic prev_nxt;

   // Previous level; reset low so a level high at release counts as a rise
   always_comb begin
      prev_nxt = level_in;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign rise = level_in & ~prev_r;
   assign fall = ~level_in & prev_r;

endmodule
`default_nettype wire

// ### src/tmo_pkg.sv
package tmo_pkg;

   // Register byte offsets on the plain register port
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] PRESET_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [3:0] ELAPSED_OFS = 4'hc;

   // Control register fields
   localparam int CTRL_GATE_BIT = 0;
   localparam int CTRL_TRIG_BIT = 1;
   localparam int CTRL_CLEAR_BIT = 2;
   localparam int CTRL_TYPE_LSB = 4;
   localparam int CTRL_TYPE_MSB = 6;
   localparam int CTRL_SYNC_BIT = 8;

   // Status register fields
   localparam int STAT_OUT_BIT = 0;
   localparam int STAT_ACTIVE_BIT = 1;
   localparam int STAT_STATE_LSB = 2;
   localparam int STAT_STATE_MSB = 3;

   // Preset limits and widths
   localparam int CNT_W = 31;
   localparam logic [30:0] PRESET_MAX = 31'h7fffffff;
   localparam logic [30:0] PRESET_RST = 31'h0000000;
   localparam int PRESET_SIGN_BIT = 31;

   // Real-time tick: one microsecond at the core clock
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_PERIOD_PS = 1000000;
   localparam int TICK_CYCLES = (TICK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Timer types as held in the control register
   typedef enum logic [2:0] {
      TT_EDGE_ON = 3'h0,
      TT_EDGE_OFF = 3'h1,
      TT_LEVEL_ON = 3'h2,
      TT_LEVEL_OFF = 3'h3,
      TT_CUM_ON = 3'h4,
      TT_CUM_OFF = 3'h5,
      TT_WATCHDOG = 3'h6,
      TT_ONE_SHOT = 3'h7
   } tmo_ttype_type;

   localparam tmo_ttype_type TYPE_RST = TT_EDGE_ON;

   // Timer sequencer states, Gray along idle-run-done-hold
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_DONE = 2'h3,
      ST_HOLD = 2'h2
   } tmo_state_type;

endpackage

// ### src/tmo_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Free-running divider producing a one-cycle pulse every CYCLES clocks
module tmo_tick_gen #(
   parameter int CYCLES = tmo_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   output logic tick
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // Count up the period; pulse on wrap
   always_comb begin
      tick_nxt = (cnt_r == LAST);
      cnt_nxt = tick_nxt ? '0 : cnt_r + CW'(1);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

endmodule
`default_nettype wire

// ### src/tmo_timer_ctrl.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

//
// Functional notes
// - Gate low keeps timed output off
// - Gate drop clears outputs and elapsed count
// - Gate acts the same for every type
// - Trigger level and type decide counting start
// - Clear zeroes count, output and counting flag
// - Level types ignore the clear
// - Clear acts on rising edge only
// - Clear request returns inactive by itself
// - Counting flag only while count advances
// - Cumulative pause drops counting flag
// - Expiry sets output (clears it for off types), drops flag together
// - Timed output fans out to several consumers
// - Preset latched at start of timing; edge-off never latches and uses the last latched preset
// - Expired count holds at preset
// - Preset non-negative, microsecond tick in real time
// - Watchdog restarts on rising edges, latches on expiry
module tmo_timer_ctrl #(
   parameter int NUM_DEST = 4,
   parameter int TICK_CYCLES = tmo_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic gate_pin,
   input wire logic trigger_pin,
   input wire logic clear_pin,
   input wire logic master_step,
   output logic [NUM_DEST-1:0] timed_output,
   output logic counting_flag,
   output logic [30:0] elapsed_count
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic ctrl_gate_r;
   logic ctrl_gate_nxt;
   logic ctrl_trig_r;
   logic ctrl_trig_nxt;
   logic ctrl_sync_r;
   logic ctrl_sync_nxt;
   tmo_pkg::tmo_ttype_type ttype_r;
   tmo_pkg::tmo_ttype_type ttype_nxt;
   logic [30:0] preset_r;
   logic [30:0] preset_nxt;
   logic [31:0] rd_data_r;
   logic [31:0] rd_data_nxt;
   logic clear_wr;

   tmo_pkg::tmo_state_type state_r;
   tmo_pkg::tmo_state_type state_nxt;
   logic [30:0] elapsed_r;
   logic [30:0] elapsed_nxt;
   logic [30:0] preset_lat_r;
   logic [30:0] preset_lat_nxt;
   logic out_r;
   logic out_nxt;
   logic active_r;
   logic active_nxt;

   logic gate_eff;
   logic trig_lvl;
   logic trig_rise;
   logic trig_fall;
   logic clr_rise;
   logic clr_evt;
   logic us_tick;
   logic tick;
   logic off_type;
   logic level_type;

   ////////////////////////////////////////////////////////////////////////////
   // Event conditioning

   // Program bits and assigned pins combine as OR, like any other destination
   assign gate_eff = ctrl_gate_r | gate_pin;
   assign trig_lvl = ctrl_trig_r | trigger_pin;

   tmo_edge_det u_trig_edge (
      .clk(clk),
      .reset(reset),
      .level_in(trig_lvl),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   // Holding the clear pin high gives only one event
   tmo_edge_det u_clear_edge (
      .clk(clk),
      .reset(reset),
      .level_in(clear_pin),
      .rise(clr_rise),
      .fall()
   );

   // A written clear is a one-cycle pulse and is never stored
   assign clear_wr = wr_en && (addr == tmo_pkg::CTRL_OFS) &&
      wr_data[tmo_pkg::CTRL_CLEAR_BIT];
   assign clr_evt = clr_rise | clear_wr;

   tmo_tick_gen #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .reset(reset),
      .tick(us_tick)
   );

   // Same domain for both timebases; master steps arrive as clk pulses
   assign tick = ctrl_sync_r ? master_step : us_tick;

   assign off_type = (ttype_r == tmo_pkg::TT_LEVEL_OFF) ||
      (ttype_r == tmo_pkg::TT_CUM_OFF) || (ttype_r == tmo_pkg::TT_EDGE_OFF);
   assign level_type = (ttype_r == tmo_pkg::TT_LEVEL_ON) ||
      (ttype_r == tmo_pkg::TT_LEVEL_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   // Writes and read data; unmapped offsets read zero
   always_comb begin
      ctrl_gate_nxt = ctrl_gate_r;
      ctrl_trig_nxt = ctrl_trig_r;
      ctrl_sync_nxt = ctrl_sync_r;
      ttype_nxt = ttype_r;
      preset_nxt = preset_r;
      rd_data_nxt = 32'h0;
      if (wr_en) begin
         if (addr == tmo_pkg::CTRL_OFS) begin
            ctrl_gate_nxt = wr_data[tmo_pkg::CTRL_GATE_BIT];
            ctrl_trig_nxt = wr_data[tmo_pkg::CTRL_TRIG_BIT];
            ctrl_sync_nxt = wr_data[tmo_pkg::CTRL_SYNC_BIT];
            ttype_nxt = tmo_pkg::tmo_ttype_type'(
               wr_data[tmo_pkg::CTRL_TYPE_MSB:tmo_pkg::CTRL_TYPE_LSB]);
         end else if (addr == tmo_pkg::PRESET_OFS &&
               !wr_data[tmo_pkg::PRESET_SIGN_BIT]) begin
            preset_nxt = wr_data[30:0];
         end
      end
      if (rd_en) begin
         unique case (addr)
            tmo_pkg::CTRL_OFS: begin
               rd_data_nxt[tmo_pkg::CTRL_GATE_BIT] = ctrl_gate_r;
               rd_data_nxt[tmo_pkg::CTRL_TRIG_BIT] = ctrl_trig_r;
               rd_data_nxt[tmo_pkg::CTRL_SYNC_BIT] = ctrl_sync_r;
               rd_data_nxt[tmo_pkg::CTRL_TYPE_MSB:tmo_pkg::CTRL_TYPE_LSB] = ttype_r;
            end
            tmo_pkg::PRESET_OFS: rd_data_nxt = {1'b0, preset_r};
            tmo_pkg::STATUS_OFS: begin
               rd_data_nxt[tmo_pkg::STAT_OUT_BIT] = out_r;
               rd_data_nxt[tmo_pkg::STAT_ACTIVE_BIT] = active_r;
               rd_data_nxt[tmo_pkg::STAT_STATE_MSB:tmo_pkg::STAT_STATE_LSB] = state_r;
            end
            tmo_pkg::ELAPSED_OFS: rd_data_nxt = {1'b0, elapsed_r};
            default: rd_data_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_gate_r <= 1'b0;
         ctrl_trig_r <= 1'b0;
         ctrl_sync_r <= 1'b0;
         ttype_r <= tmo_pkg::TYPE_RST;
         preset_r <= tmo_pkg::PRESET_RST;
         rd_data_r <= 32'h0;
      end else begin
         ctrl_gate_r <= ctrl_gate_nxt;
         ctrl_trig_r <= ctrl_trig_nxt;
         ctrl_sync_r <= ctrl_sync_nxt;
         ttype_r <= ttype_nxt;
         preset_r <= preset_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer sequencer

   // Per-type decisions first, then start and expiry applied in one place
   always_comb begin
      logic do_start;
      logic do_expire;
      logic [31:0] inc;
      do_start = 1'b0;
      do_expire = 1'b0;
      inc = {1'b0, elapsed_r} + 32'h1;
      state_nxt = state_r;
      elapsed_nxt = elapsed_r;
      preset_lat_nxt = preset_lat_r;
      out_nxt = out_r;
      if (!gate_eff) begin
         // Highest priority, whatever the type or other event
         state_nxt = tmo_pkg::ST_IDLE;
         elapsed_nxt = '0;
         out_nxt = 1'b0;
      end else if (clr_evt && !level_type) begin
         state_nxt = tmo_pkg::ST_IDLE;
         elapsed_nxt = '0;
         out_nxt = 1'b0;
      end else begin
         unique case (state_r)
            tmo_pkg::ST_IDLE: begin
               unique case (ttype_r)
                  tmo_pkg::TT_LEVEL_ON, tmo_pkg::TT_CUM_ON: do_start = trig_lvl;
                  tmo_pkg::TT_LEVEL_OFF, tmo_pkg::TT_CUM_OFF: begin
                     out_nxt = trig_lvl | trig_fall;
                     do_start = trig_fall;
                  end
                  tmo_pkg::TT_EDGE_ON, tmo_pkg::TT_ONE_SHOT: do_start = trig_rise;
                  tmo_pkg::TT_EDGE_OFF: begin
                     if (trig_rise) begin
                        state_nxt = tmo_pkg::ST_HOLD;
                        out_nxt = 1'b1;
                     end
                  end
                  tmo_pkg::TT_WATCHDOG: do_start = 1'b1;
               endcase
            end
            tmo_pkg::ST_RUN: begin
               if (ttype_r == tmo_pkg::TT_LEVEL_ON && !trig_lvl) begin
                  state_nxt = tmo_pkg::ST_IDLE;
                  elapsed_nxt = '0;
               end else if (ttype_r == tmo_pkg::TT_LEVEL_OFF && trig_lvl) begin
                  state_nxt = tmo_pkg::ST_IDLE;
                  elapsed_nxt = '0;
               end else if (ttype_r == tmo_pkg::TT_CUM_ON && !trig_lvl) begin
                  state_nxt = tmo_pkg::ST_HOLD;
               end else if (ttype_r == tmo_pkg::TT_CUM_OFF && trig_lvl) begin
                  state_nxt = tmo_pkg::ST_HOLD;
               end else if (ttype_r == tmo_pkg::TT_WATCHDOG && trig_rise) begin
                  elapsed_nxt = '0;
               end else if (tick) begin
                  if (inc >= {1'b0, preset_lat_r}) begin
                     do_expire = 1'b1;
                  end else begin
                     elapsed_nxt = inc[30:0];
                  end
               end
            end
            tmo_pkg::ST_HOLD: begin
               // Paused: cumulative count kept, or edge-off waiting for fall
               unique case (ttype_r)
                  tmo_pkg::TT_CUM_ON: begin
                     if (trig_lvl) begin
                        state_nxt = tmo_pkg::ST_RUN;
                     end
                  end
                  tmo_pkg::TT_CUM_OFF, tmo_pkg::TT_EDGE_OFF: begin
                     if (trig_fall) begin
                        state_nxt = tmo_pkg::ST_RUN;
                     end
                  end
                  default: begin
                     // Type changed under a pause; drop back cleanly
                     state_nxt = tmo_pkg::ST_IDLE;
                     elapsed_nxt = '0;
                     out_nxt = 1'b0;
                  end
               endcase
            end
            tmo_pkg::ST_DONE: begin
               // Count holds at the preset until something releases it
               if (ttype_r == tmo_pkg::TT_LEVEL_ON && !trig_lvl) begin
                  state_nxt = tmo_pkg::ST_IDLE;
                  elapsed_nxt = '0;
                  out_nxt = 1'b0;
               end else if (ttype_r == tmo_pkg::TT_LEVEL_OFF && trig_lvl) begin
                  state_nxt = tmo_pkg::ST_IDLE;
                  elapsed_nxt = '0;
                  out_nxt = 1'b1;
               end else if (ttype_r == tmo_pkg::TT_ONE_SHOT && trig_rise) begin
                  out_nxt = 1'b0;
                  do_start = 1'b1;
               end
            end
         endcase
      end
      if (do_start) begin
         // Later preset writes wait for the next start
         preset_lat_nxt = preset_r;
         elapsed_nxt = '0;
         state_nxt = tmo_pkg::ST_RUN;
         do_expire = (preset_r == '0);
      end
      if (do_expire) begin
         state_nxt = tmo_pkg::ST_DONE;
         elapsed_nxt = preset_lat_nxt;
         out_nxt = ~off_type;
      end
      // Flag follows the next state, so it falls in the expiry cycle
      active_nxt = (state_nxt == tmo_pkg::ST_RUN);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= tmo_pkg::ST_IDLE;
         elapsed_r <= '0;
         preset_lat_r <= tmo_pkg::PRESET_RST;
         out_r <= 1'b0;
         active_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         elapsed_r <= elapsed_nxt;
         preset_lat_r <= preset_lat_nxt;
         out_r <= out_nxt;
         active_r <= active_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // One flop per consumer keeps each copy a clean register output
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timed_output <= '0;
      end else begin
         timed_output <= {NUM_DEST{out_nxt}};
      end
   end

   assign counting_flag = active_r;
   assign elapsed_count = elapsed_r;
   assign rd_data = rd_data_r;

endmodule
`default_nettype wire

// ### testbench/tmo_master_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Master encoder stand-in: a loaded count of distance pulses
module tmo_master_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [7:0] count,
   output logic master_step,
   output logic busy
);
   logic [7:0] left_r;
   // Pulses are spaced by an idle cycle so each unit is seen alone
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         left_r <= 8'h00;
         master_step <= 1'b0;
      end else if (load) begin
         left_r <= count;
         master_step <= 1'b0;
      end else begin
         master_step <= left_r != 8'h00 && !master_step;
         if (left_r != 8'h00 && !master_step) begin
            left_r <= left_r - 8'h01;
         end
      end
   end
   assign busy = left_r != 8'h00 || master_step;
endmodule
`default_nettype wire

// ### testbench/tmo_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Port-level checks; control bits are mirrored from writes at the same edge
module tmo_timer_checker #(
   parameter int NUM_DEST = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   input wire logic gate_pin,
   input wire logic trigger_pin,
   input wire logic clear_pin,
   input wire logic master_step,
   input wire logic [NUM_DEST-1:0] timed_output,
   input wire logic counting_flag,
   input wire logic [30:0] elapsed_count
);
   logic [8:0] ctl_r;
   logic [8:0] ctl_nxt;
   logic gate_eff;
   logic trig_eff;
   logic level_t;
   logic idle_o;
   // Mirror the low nine bits of each control write; the clear bit is copied too but never used
   always_comb begin
      ctl_nxt = ctl_r;
      if (wr_en && addr == tmo_pkg::CTRL_OFS) begin
         ctl_nxt = wr_data[8:0];
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_r <= 9'h000;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end
   // Pins and control bits are ORed, as in the block
   assign gate_eff = gate_pin | ctl_r[0];
   assign trig_eff = trigger_pin | ctl_r[1];
   assign level_t = ctl_r[6:4] == 3'h2 || ctl_r[6:4] == 3'h3;
   assign idle_o = timed_output == '0 && !counting_flag && elapsed_count == 31'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_gate_off_idle: assert property (!gate_eff |=> idle_o)
      else $error("outputs busy while gate off");
   a_out_copies: assert property (timed_output == '0 || &timed_output)
      else $error("output copies differ");
   a_expiry_flag: assert property ($rose(timed_output[0]) |-> !counting_flag)
      else $error("flag high as output rose");
   a_clear_idle: assert property (!level_t && $rose(clear_pin) |=> idle_o)
      else $error("clear edge did not idle timer");
   a_level_keeps: assert property (level_t && gate_eff && timed_output[0] && !counting_flag
      && $rose(clear_pin) && $stable(trig_eff) && !wr_en |=> timed_output[0])
      else $error("level type obeyed clear");
   a_count_held: assert property (!counting_flag |=>
      elapsed_count == $past(elapsed_count) || elapsed_count == 31'h0)
      else $error("count moved without flag");
   a_count_step: assert property (elapsed_count != $past(elapsed_count) && elapsed_count != 31'h0
      |-> elapsed_count == $past(elapsed_count) + 31'h1 && $past(counting_flag)
      && ($past(master_step) || !$past(ctl_r[8])))
      else $error("count step wrong");
   a_rd_quiet: assert property (!rd_en |=> rd_data == 32'h0)
      else $error("read data without read");
   a_clear_reads0: assert property (rd_en && addr == tmo_pkg::CTRL_OFS |=> !rd_data[2])
      else $error("clear bit read back high");
endmodule
`default_nettype wire

// ### testbench/tmo_timer_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module tmo_timer_ctrl_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic gate_pin = 1'b0;
   logic trigger_pin = 1'b0;
   logic clear_pin = 1'b0;
   logic master_step;
   logic [3:0] timed_output;
   logic counting_flag;
   logic [30:0] elapsed_count;
   logic load = 1'b0;
   logic [7:0] count = 8'h00;
   logic busy;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   tmo_timer_ctrl #(.NUM_DEST(4), .TICK_CYCLES(5)) tmo_timer_ctrl_i (.clk(clk),
      .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .gate_pin(gate_pin), .trigger_pin(trigger_pin),
      .clear_pin(clear_pin), .master_step(master_step), .timed_output(timed_output),
      .counting_flag(counting_flag), .elapsed_count(elapsed_count));
   tmo_master_model tmo_master_model_i (.clk(clk), .reset(reset), .load(load),
      .count(count), .master_step(master_step), .busy(busy));
   always #2 clk = ~clk;
   task automatic summarize();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
   endtask
   task automatic pins(input logic t, input logic c);
      @(posedge clk);
      trigger_pin <= t;
      clear_pin <= c;
      repeat (3) @(posedge clk);
   endtask
   // Bounded wait on the master model, then two edges for the count to land
   task automatic step(input logic [7:0] k);
      @(posedge clk);
      load <= 1'b1;
      count <= k;
      @(posedge clk);
      load <= 1'b0;
      // Busy read at the load edge still shows the old count
      @(posedge clk);
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   // Cycle ceiling well above the sequence length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(tmo_pkg::CTRL_OFS, 32'h0);
      rd(tmo_pkg::PRESET_OFS, 32'h0);
      rd(tmo_pkg::STATUS_OFS, 32'h0);
      rd(4'h2, 32'h0);
      wr(tmo_pkg::PRESET_OFS, 32'h3);
      wr(tmo_pkg::CTRL_OFS, 32'h101);
      pins(1'b1, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'h6);
      step(8'h2);
      wr(tmo_pkg::PRESET_OFS, 32'h9);
      step(8'h1);
      rd(tmo_pkg::STATUS_OFS, 32'hd);
      rd(tmo_pkg::ELAPSED_OFS, 32'h3);
      step(8'h2);
      rd(tmo_pkg::ELAPSED_OFS, 32'h3);
      pins(1'b0, 1'b1);
      rd(tmo_pkg::STATUS_OFS, 32'h0);
      pins(1'b1, 1'b1);
      rd(tmo_pkg::STATUS_OFS, 32'h6);
      pins(1'b0, 1'b0);
      step(8'h1);
      gate_pin <= 1'b1;
      wr(tmo_pkg::CTRL_OFS, 32'h100);
      // Gate falls in the same cycle as a clear edge
      gate_pin <= 1'b0;
      clear_pin <= 1'b1;
      repeat (2) @(posedge clk);
      clear_pin <= 1'b0;
      rd(tmo_pkg::ELAPSED_OFS, 32'h0);
      wr(tmo_pkg::PRESET_OFS, 32'h80000002);
      rd(tmo_pkg::PRESET_OFS, 32'h9);
      wr(tmo_pkg::PRESET_OFS, 32'h7fffffff);
      rd(tmo_pkg::PRESET_OFS, 32'h7fffffff);
      wr(tmo_pkg::PRESET_OFS, 32'h1);
      wr(tmo_pkg::CTRL_OFS, 32'h101);
      pins(1'b1, 1'b0);
      step(8'h1);
      wr(tmo_pkg::CTRL_OFS, 32'h105);
      rd(tmo_pkg::CTRL_OFS, 32'h101);
      rd(tmo_pkg::STATUS_OFS, 32'h0);
      wr(tmo_pkg::CTRL_OFS, 32'h100);
      wr(tmo_pkg::CTRL_OFS, 32'h121);
      step(8'h1);
      pins(1'b1, 1'b1);
      rd(tmo_pkg::STATUS_OFS, 32'hd);
      pins(1'b0, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'h0);
      wr(tmo_pkg::CTRL_OFS, 32'h131);
      pins(1'b1, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'h1);
      pins(1'b0, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'h7);
      step(8'h1);
      chk({27'h0, timed_output, counting_flag}, 32'h0);
      wr(tmo_pkg::CTRL_OFS, 32'h100);
      wr(tmo_pkg::PRESET_OFS, 32'h2);
      wr(tmo_pkg::CTRL_OFS, 32'h141);
      pins(1'b1, 1'b0);
      step(8'h1);
      pins(1'b0, 1'b0);
      chk({31'h0, counting_flag}, 32'h0);
      rd(tmo_pkg::ELAPSED_OFS, 32'h1);
      pins(1'b1, 1'b0);
      step(8'h1);
      rd(tmo_pkg::STATUS_OFS, 32'hd);
      pins(1'b0, 1'b0);
      wr(tmo_pkg::CTRL_OFS, 32'h100);
      wr(tmo_pkg::PRESET_OFS, 32'h3);
      wr(tmo_pkg::CTRL_OFS, 32'h161);
      step(8'h2);
      pins(1'b1, 1'b0);
      rd(tmo_pkg::ELAPSED_OFS, 32'h0);
      pins(1'b0, 1'b0);
      step(8'h3);
      pins(1'b1, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'hd);
      rd(tmo_pkg::ELAPSED_OFS, 32'h3);
      // Every type, mid-count except level-on, returns to idle with output, flag and count cleared when the gate drops
      wr(tmo_pkg::PRESET_OFS, 32'h9);
      for (int t = 0; t < 8; t++) begin
         wr(tmo_pkg::CTRL_OFS, 32'h100);
         pins(1'b0, 1'b0);
         wr(tmo_pkg::CTRL_OFS, 32'h101 | (t << 4));
         pins(1'b1, 1'b0);
         step(8'h1);
         pins(1'b0, 1'b0);
         step(8'h1);
         wr(tmo_pkg::CTRL_OFS, 32'h100);
         rd(tmo_pkg::STATUS_OFS, 32'h0);
         rd(tmo_pkg::ELAPSED_OFS, 32'h0);
      end
      // Real-time base: one count per tick
      wr(tmo_pkg::PRESET_OFS, 32'h4);
      wr(tmo_pkg::CTRL_OFS, 32'h001);
      @(posedge clk);
      trigger_pin <= 1'b1;
      n = 0;
      while (n < 200 && timed_output[0] !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= 15 && n <= 25), 32'h1);
      rd(tmo_pkg::ELAPSED_OFS, 32'h4);
      wr(tmo_pkg::CTRL_OFS, 32'h100);
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b0);
      rd(tmo_pkg::STATUS_OFS, 32'h0);
      summarize();
   end
endmodule
bind tmo_timer_ctrl tmo_timer_checker #(.NUM_DEST(NUM_DEST)) tmo_timer_checker_i (
   .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .gate_pin(gate_pin), .trigger_pin(trigger_pin),
   .clear_pin(clear_pin), .master_step(master_step), .timed_output(timed_output),
   .counting_flag(counting_flag), .elapsed_count(elapsed_count));
`default_nettype wire
